// ===== dco_pkg.sv
// shared constants and carrier types for the display cursor overlay stage
package dco_pkg;
    // cursor bitmap geometry
    localparam int CUR_DIM = 32;
    localparam int CUR_AW = 10;
    localparam int CUR_BYTES = 2048;
    localparam int CUR_DW = 16;
    localparam int FB_AW = 24;
    localparam logic [23:0] CUR_WORD_BYTES = 24'h000002;
    localparam logic [9:0] CUR_LAST_IDX = 10'h3FF;
    // cursor pixel field positions
    localparam int CUR_MODE_BIT = 15;
    localparam int CUR_R_LSB = 10;
    localparam int CUR_G_LSB = 5;
    localparam int CUR_B_LSB = 0;
    localparam int CC_W = 5;
    localparam logic [15:0] CUR_TRANSPARENT = 16'h0000;
    localparam logic [15:0] CUR_INVERT = 16'h7FFF;
    // display pixel layout, 10 bits per colour
    localparam int COMP_W = 10;
    localparam int RGB_W = 30;
    localparam int COORD_W = 11;
    localparam int LINE_AW = 10;
    localparam int LINE_BUFS = 4;
    // scaling steps are 2.8 fixed point, 10'h100 means 1.0
    localparam int SCALE_W = 10;
    localparam int SCALE_FRAC = 8;
    localparam logic [9:0] SCALE_ONE = 10'h100;
    // output buffering
    localparam int FIFO_DEPTH = 32;
    localparam int PIPE_SLACK = 4;
    // reset values
    localparam logic [1:0] WSEL_RST = 2'h0;
    localparam logic [9:0] IDX_RST = 10'h000;
    localparam logic [23:0] ADDR_RST = 24'h000000;

    typedef struct packed {
        logic [29:0] rgb;
        logic video;
        logic active;
        logic hsync;
        logic vsync;
        logic [10:0] x;
        logic [10:0] y;
    } dco_pix_in_type;

    typedef struct packed {
        logic [29:0] rgb;
        logic hsync;
        logic vsync;
        logic csync;
        logic active;
    } dco_pix_out_type;

    typedef struct packed {
        logic video;
        logic [29:0] rgb;
    } dco_line_word_type;

    typedef enum logic {
        FS_IDLE,
        FS_REQ
    } dco_fetch_state_type;
endpackage

// ===== dco_ram.sv
// simple dual port memory with registered read data
`timescale 1ns/10ps
`default_nettype none
module dco_ram #(
    parameter int AW = 10,
    parameter int DW = 16
) (
    // clocking
    input wire logic sys_clk,
    input wire logic clk_en,
    // write port
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [DW-1:0] wdata,
    // read port, old data on a same-address collision
    input wire logic [AW-1:0] raddr,
    output logic [DW-1:0] rdata_q
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    // storage write
    always_ff @(posedge sys_clk) begin
        if (clk_en && we) begin
            mem[waddr] <= wdata;
        end
    end

    // registered read
    always_ff @(posedge sys_clk) begin
        if (clk_en) begin
            rdata_q <= mem[raddr];
        end
    end
endmodule
`default_nettype wire

// ===== dco_fifo.sv
// synchronous fifo with registered output stage and fill level
`timescale 1ns/10ps
`default_nettype none
module dco_fifo #(
    parameter int DW = 34,
    parameter int DEPTH = 32
) (
    // clocking
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [DW-1:0] in_data,
    // drain side
    output logic out_valid_q,
    input wire logic out_ready,
    output logic [DW-1:0] out_data_q,
    // status
    output logic [$clog2(DEPTH):0] level_q
);
    localparam int PW = $clog2(DEPTH);
    logic [DW-1:0] mem [0:DEPTH-1];
    logic [PW-1:0] wp_q;
    logic [PW-1:0] rp_q;
    logic push;
    logic pop;

    // handshakes, the output register refills when empty or drained
    assign in_ready = (level_q != (PW+1)'(DEPTH));
    assign push = clk_en && in_valid && in_ready;
    assign pop = clk_en && (level_q != '0) && (!out_valid_q || out_ready);

    // storage
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wp_q] <= in_data;
        end
    end

    // pointers and level
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wp_q <= '0;
            rp_q <= '0;
            level_q <= '0;
        end else begin
            if (push) begin
                wp_q <= wp_q + PW'(1);
            end
            if (pop) begin
                rp_q <= rp_q + PW'(1);
            end
            if (push && !pop) begin
                level_q <= level_q + (PW+1)'(1);
            end else if (pop && !push) begin
                level_q <= level_q - (PW+1)'(1);
            end
        end
    end

    // output register
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            out_valid_q <= 1'b0;
            out_data_q <= '0;
        end else if (pop) begin
            out_valid_q <= 1'b1;
            out_data_q <= mem[rp_q];
        end else if (clk_en && out_ready) begin
            out_valid_q <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ===== dco_overlay.sv
// display output pixel stage: flicker filter, scaling window, cursor merge
`timescale 1ns/10ps
`default_nettype none
// Function
// R1 - 32x32 cursor, 15-bit 5:5:5 colour
// R2 - fetch cursor from 2KB framestore bitmap
// R3 - widen 5-bit components to 10 by replication
// R4 - bit 15 set replaces, clear XORs
// R5 - red 14:10, green 9:5, blue 4:0
// R6 - zero cursor pixel is transparent
// R7 - 0x7FFF cursor pixel inverts display
// R8 - cursor lies on top of video
// R9 - software enables cursor, base, coordinates
// R10 - software changes cursor during retrace only
// R11 - software disables unused cursor
// R12 - line lengths are 4/2/1 pixel multiples
// R13 - flicker filter selectable on or off
// R14 - filter weights above/centre/below total one
// R15 - filter framestore pixels, never the cursor
// R16 - never filter video overlay pixels
// R17 - scaling and position for over/underscan
// R18 - composite sync for tv output
module dco_overlay #(
    parameter int FIFO_D = dco_pkg::FIFO_DEPTH
) (
    // clock, reset, enable
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    // control
    input wire logic cursor_en,
    input wire logic [23:0] cursor_base,
    input wire logic [10:0] cursor_x,
    input wire logic [10:0] cursor_y,
    input wire logic flicker_en,
    input wire logic tv_mode,
    input wire logic [9:0] hscale_step,
    input wire logic [9:0] vscale_step,
    input wire logic [10:0] image_x,
    input wire logic [10:0] image_y,
    input wire logic [12:0] image_w,
    input wire logic [12:0] image_h,
    // framestore fetch port
    output logic fb_req_q,
    output logic [23:0] fb_addr_q,
    input wire logic fb_ack,
    input wire logic [15:0] fb_rdata,
    output logic fetch_busy_q,
    // pixel stream in
    input wire logic in_valid,
    output logic in_ready_q,
    input wire dco_pkg::dco_pix_in_type in_pix,
    // pixel stream out to the dacs
    output logic out_valid_q,
    input wire logic out_ready,
    output dco_pkg::dco_pix_out_type out_pix_q
);
    localparam int OW = $bits(dco_pkg::dco_pix_out_type);
    localparam int LW = $bits(dco_pkg::dco_line_word_type);

    dco_pkg::dco_fetch_state_type fs_q;
    logic [9:0] idx_q;
    logic in_take;
    logic hs_prev_q;
    logic vs_prev_q;
    logic [1:0] wsel_q;
    logic [10:0] dx;
    logic [10:0] dy;
    logic hit0;
    logic [20:0] hprod;
    logic [20:0] vprod;
    logic [12:0] sx;
    logic [12:0] sy;
    logic win0;
    logic [LW-1:0] lb_rdata [0:dco_pkg::LINE_BUFS-1];
    logic [15:0] cur_q;
    logic v1_q;
    logic hit1_q;
    logic win1_q;
    logic [1:0] wsel1_q;
    dco_pkg::dco_pix_in_type p1_q;
    dco_pkg::dco_line_word_type above;
    dco_pkg::dco_line_word_type center;
    dco_pkg::dco_line_word_type below;
    logic [29:0] filt;
    logic [29:0] disp;
    logic [29:0] crgb;
    logic [29:0] merged;
    logic cur_on;
    dco_pkg::dco_pix_out_type p2_d;
    dco_pkg::dco_pix_out_type p2_q;
    logic v2_q;
    logic fifo_in_rdy;
    logic [$clog2(FIFO_D):0] fifo_level;

    // input acceptance
    assign in_take = clk_en && in_valid && in_ready_q;

    // back-pressure: stop taking pixels while the pipeline could overfill the fifo
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            in_ready_q <= 1'b0;
        end else if (clk_en) begin
            in_ready_q <= fifo_in_rdy &&
                (fifo_level <= ($clog2(FIFO_D)+1)'(FIFO_D - dco_pkg::PIPE_SLACK));
        end
    end

    // sync edge history on accepted stream cells
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            hs_prev_q <= 1'b0;
            vs_prev_q <= 1'b0;
        end else if (in_take) begin
            hs_prev_q <= in_pix.hsync;
            vs_prev_q <= in_pix.vsync;
        end
    end

    // R12 line buffers rotate once per line
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wsel_q <= dco_pkg::WSEL_RST;
        end else if (in_take && in_pix.hsync && !hs_prev_q) begin
            wsel_q <= wsel_q + 2'h1;
        end
    end

    // cursor fetch state machine, starts at retrace
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            fs_q <= dco_pkg::FS_IDLE;
            fb_req_q <= 1'b0;
            fb_addr_q <= dco_pkg::ADDR_RST;
            idx_q <= dco_pkg::IDX_RST;
            fetch_busy_q <= 1'b0;
        end else if (clk_en) begin
            case (fs_q)
                dco_pkg::FS_IDLE: begin
                    // R2 load bitmap
                    if (in_take && in_pix.vsync && !vs_prev_q && cursor_en) begin
                        fs_q <= dco_pkg::FS_REQ;
                        fb_req_q <= 1'b1;
                        fb_addr_q <= cursor_base;
                        idx_q <= dco_pkg::IDX_RST;
                        fetch_busy_q <= 1'b1;
                    end
                end
                dco_pkg::FS_REQ: begin
                    if (fb_ack) begin
                        if (idx_q == dco_pkg::CUR_LAST_IDX) begin
                            fs_q <= dco_pkg::FS_IDLE;
                            fb_req_q <= 1'b0;
                            fetch_busy_q <= 1'b0;
                        end else begin
                            idx_q <= idx_q + 10'h001;
                            fb_addr_q <= fb_addr_q + dco_pkg::CUR_WORD_BYTES;
                        end
                    end
                end
                default: begin
                    fs_q <= dco_pkg::FS_IDLE;
                end
            endcase
        end
    end

    // R1 cursor hit test on the incoming raster position
    assign dx = in_pix.x - cursor_x;
    assign dy = in_pix.y - cursor_y;
    assign hit0 = (in_pix.x >= cursor_x) && (dx < 11'(dco_pkg::CUR_DIM)) &&
        (in_pix.y >= cursor_y) && (dy < 11'(dco_pkg::CUR_DIM));

    // R17 map raster to source column and image window
    assign hprod = (in_pix.x - image_x) * hscale_step;
    assign vprod = (in_pix.y - image_y) * vscale_step;
    assign sx = hprod[20:dco_pkg::SCALE_FRAC];
    assign sy = vprod[20:dco_pkg::SCALE_FRAC];
    assign win0 = (in_pix.x >= image_x) && (in_pix.y >= image_y) &&
        (sx < image_w) && (sy < image_h);

    // cursor bitmap store
    dco_ram #(
        .AW(dco_pkg::CUR_AW),
        .DW(dco_pkg::CUR_DW)
    ) u_cursor_ram (
        .sys_clk(sys_clk),
        .clk_en(clk_en),
        .we(fs_q == dco_pkg::FS_REQ && fb_ack),
        .waddr(idx_q),
        .wdata(fb_rdata),
        .raddr({dy[4:0], dx[4:0]}),
        .rdata_q(cur_q)
    );

    // line buffers, written at the raster column, read at the scaled column
    for (genvar i = 0; i < dco_pkg::LINE_BUFS; i++) begin : g_lb
        dco_ram #(
            .AW(dco_pkg::LINE_AW),
            .DW(LW)
        ) u_line_ram (
            .sys_clk(sys_clk),
            .clk_en(clk_en),
            .we(in_take && in_pix.active && (wsel_q == 2'(i))),
            .waddr(in_pix.x[9:0]),
            .wdata({in_pix.video, in_pix.rgb}),
            .raddr(sx[9:0]),
            .rdata_q(lb_rdata[i])
        );
    end

    // stage 1 registers, aligned with memory read data
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            v1_q <= 1'b0;
            hit1_q <= 1'b0;
            win1_q <= 1'b0;
            wsel1_q <= dco_pkg::WSEL_RST;
            p1_q <= '0;
        end else if (clk_en) begin
            v1_q <= in_take;
            hit1_q <= hit0;
            win1_q <= win0;
            wsel1_q <= wsel_q;
            p1_q <= in_pix;
        end
    end

    // three completed lines around the displayed line
    assign below = lb_rdata[wsel1_q - 2'h1];
    assign center = lb_rdata[wsel1_q - 2'h2];
    assign above = lb_rdata[wsel1_q - 2'h3];

    // R14 quarter, half, quarter per colour component
    always_comb begin
        filt = '0;
        for (int c = 0; c < 3; c++) begin
            filt[c*10 +: 10] = 10'(({2'h0, above.rgb[c*10 +: 10]} +
                {1'b0, center.rgb[c*10 +: 10], 1'b0} +
                {2'h0, below.rgb[c*10 +: 10]}) >> 2);
        end
    end

    // R13 optional filter; R16 video pixels bypass it
    assign disp = (flicker_en && !center.video) ? filt : center.rgb;

    // R3 R5 widen 5-bit fields by replication
    assign crgb = {cur_q[14:10], cur_q[14:10], cur_q[9:5], cur_q[9:5],
        cur_q[4:0], cur_q[4:0]};

    // R9 R6 cursor only where enabled, hit and not transparent
    assign cur_on = cursor_en && hit1_q &&
        (cur_q[14:0] != dco_pkg::CUR_TRANSPARENT[14:0] || cur_q[dco_pkg::CUR_MODE_BIT]);

    // R4 R7 R8 R15 replace or XOR on top of filtered data and video
    always_comb begin
        if (!cur_on) begin
            merged = disp;
        end else if (cur_q[dco_pkg::CUR_MODE_BIT]) begin
            merged = crgb;
        end else begin
            merged = disp ^ crgb;
        end
    end

    // stage 2 value: border blanking outside the image window except under the cursor, syncs
    always_comb begin
        p2_d.rgb = '0;
        if (p1_q.active && (win1_q || cur_on)) begin
            p2_d.rgb = win1_q ? merged : crgb;
        end
        p2_d.hsync = p1_q.hsync;
        p2_d.vsync = p1_q.vsync;
        // R18 composite sync in tv mode
        p2_d.csync = tv_mode ? (p1_q.hsync ^ p1_q.vsync) : p1_q.hsync;
        p2_d.active = p1_q.active;
    end

    // stage 2 registers feeding the fifo
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            v2_q <= 1'b0;
            p2_q <= '0;
        end else if (clk_en) begin
            v2_q <= v1_q;
            p2_q <= p2_d;
        end
    end

    // output buffering toward the dacs
    dco_fifo #(
        .DW(OW),
        .DEPTH(FIFO_D)
    ) u_out_fifo (
        .sys_clk(sys_clk),
        .rst(rst),
        .clk_en(clk_en),
        .in_valid(v2_q),
        .in_ready(fifo_in_rdy),
        .in_data(p2_q),
        .out_valid_q(out_valid_q),
        .out_ready(out_ready),
        .out_data_q(out_pix_q),
        .level_q(fifo_level)
    );

    // checks on the merge, filter, sync, border and fetch paths
    property p_replace;
        @(posedge sys_clk) disable iff (rst)
        (clk_en && v1_q && cur_on && win1_q && p1_q.active && cur_q[15]) |=>
            (p2_q.rgb == $past(crgb));
    endproperty
    a_replace: assert property (p_replace) else $error("replace mode lost"); // R4

    property p_xor;
        @(posedge sys_clk) disable iff (rst)
        (clk_en && v1_q && cur_on && win1_q && p1_q.active && !cur_q[15]) |=>
            (p2_q.rgb == ($past(disp) ^ $past(crgb)));
    endproperty
    a_xor: assert property (p_xor) else $error("xor mode wrong"); // R4

    property p_transparent;
        @(posedge sys_clk) disable iff (rst)
        (clk_en && v1_q && win1_q && p1_q.active && cur_q == dco_pkg::CUR_TRANSPARENT) |=>
            (p2_q.rgb == $past(disp));
    endproperty
    a_transparent: assert property (p_transparent) else $error("zero cursor not clear"); // R6

    property p_invert;
        @(posedge sys_clk) disable iff (rst)
        (clk_en && v1_q && cursor_en && hit1_q && win1_q && p1_q.active &&
            cur_q == dco_pkg::CUR_INVERT) |=> (p2_q.rgb == ~$past(disp));
    endproperty
    a_invert: assert property (p_invert) else $error("inversion wrong"); // R7

    property p_widen;
        @(posedge sys_clk) disable iff (rst)
        (crgb[29:25] == cur_q[14:10]) && (crgb[24:20] == cur_q[14:10]) &&
            (crgb[19:15] == cur_q[9:5]) && (crgb[14:10] == cur_q[9:5]) &&
            (crgb[4:0] == cur_q[4:0]) && (crgb[9:5] == cur_q[4:0]);
    endproperty
    a_widen: assert property (p_widen) else $error("colour widening wrong"); // R3

    property p_disabled;
        @(posedge sys_clk) disable iff (rst)
        (clk_en && v1_q && !cursor_en && win1_q && p1_q.active) |=>
            (p2_q.rgb == $past(disp));
    endproperty
    a_disabled: assert property (p_disabled) else $error("cursor shown while off"); // R9

    property p_video_unfiltered;
        @(posedge sys_clk) disable iff (rst)
        center.video |-> (disp == center.rgb);
    endproperty
    a_video_unfiltered: assert property (p_video_unfiltered) else $error("video filtered"); // R16

    property p_unity_gain;
        @(posedge sys_clk) disable iff (rst)
        (above.rgb == center.rgb && below.rgb == center.rgb) |-> (filt == center.rgb);
    endproperty
    a_unity_gain: assert property (p_unity_gain) else $error("filter gain not one"); // R14

    property p_csync;
        @(posedge sys_clk) disable iff (rst)
        (clk_en && tv_mode) |=> (p2_q.csync == ($past(p1_q.hsync) ^ $past(p1_q.vsync)));
    endproperty
    a_csync: assert property (p_csync) else $error("composite sync wrong"); // R18

    property p_fetch_start;
        @(posedge sys_clk) disable iff (rst)
        (clk_en && fs_q == dco_pkg::FS_IDLE && in_take && in_pix.vsync && !vs_prev_q &&
            cursor_en) |=> (fb_req_q && fb_addr_q == $past(cursor_base));
    endproperty
    a_fetch_start: assert property (p_fetch_start) else $error("fetch not started"); // R2

    property p_border;
        @(posedge sys_clk) disable iff (rst)
        (clk_en && v1_q && !win1_q && !cur_on) |=> (p2_q.rgb == 30'h0);
    endproperty
    a_border: assert property (p_border) else $error("border not blank"); // R17

    c_replace: cover property (@(posedge sys_clk) v1_q && cur_on && cur_q[15]);
    c_xor: cover property (@(posedge sys_clk) v1_q && cur_on && !cur_q[15]);
    c_filter: cover property (@(posedge sys_clk) v1_q && flicker_en && !center.video);
    c_fetch_done: cover property (@(posedge sys_clk) fb_ack && idx_q == 10'h3FF);
endmodule
`default_nettype wire

// ===== dco_sink.sv
// stall-prone pixel consumer standing in for the dac side
`timescale 1ns/10ps
`default_nettype none
module dco_sink (
    // clocking
    input wire logic sys_clk,
    input wire logic rst,
    // bench control, high stalls the stream completely
    input wire logic hold,
    // pixel stream
    input wire logic out_valid_q,
    output logic out_ready
);
    integer seed = 32'hA83E;
    // ready starts low so nothing is taken before the first edge
    initial out_ready = 1'b0;
    // accept on about three cycles in four, offered or not
    always @(negedge sys_clk) begin
        out_ready <= !rst && !hold && (($random(seed) & 3) != 0);
    end
endmodule
`default_nettype wire

// ===== test_dco_overlay.sv
// self-checking bench for the display cursor overlay stage
`timescale 1ns/10ps
`default_nettype none
module test_dco_overlay;
    // stimulus and observed signals
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic cursor_en = 1'b0;
    logic flicker_en = 1'b0;
    logic tv_mode = 1'b0;
    logic hold = 1'b0;
    logic [23:0] cursor_base = 24'h1F0800;
    logic [10:0] cursor_x = 11'h004;
    logic [10:0] cursor_y = 11'h004;
    logic [10:0] image_x = 11'h000;
    logic [9:0] hscale_step = dco_pkg::SCALE_ONE;
    logic [9:0] vscale_step = dco_pkg::SCALE_ONE;
    logic [12:0] image_h = 13'h1000;
    logic fb_ack = 1'b0;
    logic [15:0] fb_rdata = 16'h0000;
    logic in_valid = 1'b0;
    dco_pkg::dco_pix_in_type in_pix = '0;
    wire logic out_ready;
    logic fb_req_q, fetch_busy_q, in_ready_q, out_valid_q, mon_chk;
    logic [23:0] fb_addr_q;
    dco_pkg::dco_pix_out_type out_pix_q, mon_exp;
    // reference tables and scoreboard
    logic [15:0] curmem [0:1023];
    logic [29:0] bgtab [0:63];
    dco_pkg::dco_pix_out_type exp_q [$];
    logic chk_q [$];
    integer seed = 32'hA83E;
    integer n_mismatch = 0;
    integer samples_checked = 0;
    integer nack = 0;

    // 200 MHz clock
    always #2.5 sys_clk = ~sys_clk;

    dco_overlay #(.FIFO_D(32)) i_dco_overlay (.sys_clk(sys_clk), .rst(rst), .clk_en(1'b1),
        .cursor_en(cursor_en), .cursor_base(cursor_base), .cursor_x(cursor_x),
        .cursor_y(cursor_y), .flicker_en(flicker_en), .tv_mode(tv_mode),
        .hscale_step(hscale_step), .vscale_step(vscale_step), .image_x(image_x),
        .image_y(11'h000), .image_w(13'h1000), .image_h(image_h), .fb_req_q(fb_req_q),
        .fb_addr_q(fb_addr_q), .fb_ack(fb_ack), .fb_rdata(fb_rdata),
        .fetch_busy_q(fetch_busy_q), .in_valid(in_valid), .in_ready_q(in_ready_q),
        .in_pix(in_pix), .out_valid_q(out_valid_q), .out_ready(out_ready),
        .out_pix_q(out_pix_q));

    dco_sink i_dco_sink (.sys_clk(sys_clk), .rst(rst), .hold(hold),
        .out_valid_q(out_valid_q), .out_ready(out_ready));

    task automatic fail(input string m);
        n_mismatch++;
        $display("CHECK FAILED at %0t: %s", $time, m);
    endtask

    task automatic cmp_pix(input dco_pkg::dco_pix_out_type got, input dco_pkg::dco_pix_out_type ex);
        samples_checked++;
        if (got !== ex) fail($sformatf("pixel %h expected %h", got, ex));
    endtask

    task automatic cmp_addr(input logic [23:0] got, input logic [23:0] ex);
        samples_checked++;
        if (got !== ex) fail($sformatf("fetch address %h expected %h", got, ex));
    endtask

    task automatic cmp_val(input logic [31:0] got, input logic [31:0] ex);
        samples_checked++;
        if (got !== ex) fail($sformatf("value %h expected %h", got, ex));
    endtask

    task automatic conclude;
        $display("mismatches %0d, comparisons %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // expected output cell from window, scaling, cursor and sync settings
    function automatic dco_pkg::dco_pix_out_type expect_pix(input logic [10:0] x, input logic [10:0] y,
        input logic act, input logic hs, input logic vs);
        logic [29:0] d;
        logic [29:0] c;
        logic [15:0] w;
        logic [29:0] la, lc, lb;
        logic [10:0] sx, dx, dy, ly;
        logic [20:0] pr, pv;
        sx = x - image_x;
        pr = sx * hscale_step;
        pv = y * vscale_step;
        // displayed line is two lines back, neighbours one line either side
        ly = y - 11'h002;
        la = bgtab[pr[13:8] ^ {ly[1:0] - 2'h1, 4'h0}];
        lc = bgtab[pr[13:8] ^ {ly[1:0], 4'h0}];
        lb = bgtab[pr[13:8] ^ {ly[1:0] + 2'h1, 4'h0}];
        d = lc;
        // quarter, half, quarter weights; video columns (bit 1 set) stay unfiltered
        if (flicker_en && !pr[9]) begin
            for (int k = 0; k < 30; k += 10) begin
                d[k +: 10] = 10'((12'(la[k +: 10]) + 12'h2 * 12'(lc[k +: 10]) +
                    12'(lb[k +: 10])) / 12'h4);
            end
        end
        d = (act && x >= image_x && pv[20:8] < image_h) ? d : 30'h0;
        dx = x - cursor_x;
        dy = y - cursor_y;
        w = (cursor_en && act && dx < 11'h020 && dy < 11'h020) ? curmem[{dy[4:0], dx[4:0]}] : 16'h0;
        c = {w[14:10], w[14:10], w[9:5], w[9:5], w[4:0], w[4:0]};
        d = w[15] ? c : d ^ c;
        return {d, hs, vs, tv_mode ? hs ^ vs : hs, act};
    endfunction

    // offer one cell and hold it until taken
    task automatic send(input logic [10:0] x, input logic [10:0] y, input logic act,
        input logic hs, input logic vs, input logic chk);
        int w;
        @(negedge sys_clk);
        in_valid = 1'b1;
        in_pix = {bgtab[x[5:0] ^ {y[1:0], 4'h0}], x[1], act, hs, vs, x, y};
        exp_q.push_back(expect_pix(x, y, act, hs, vs));
        chk_q.push_back(chk);
        w = 0;
        while (in_ready_q !== 1'b1 && w < 5000) begin
            @(negedge sys_clk);
            w++;
        end
        if (w >= 5000) fail("input never ready");
        @(posedge sys_clk);
        #1;
    endtask

    // stop offering and wait until every noted result has come out
    task automatic drain;
        int w;
        @(negedge sys_clk);
        in_valid = 1'b0;
        w = 0;
        while (exp_q.size() != 0 && w < 20000) begin
            @(negedge sys_clk);
            w++;
        end
        if (w >= 20000) fail("results still missing");
        repeat (2) @(negedge sys_clk);
        cmp_val({31'h0, out_valid_q}, 32'h0);
    endtask

    task automatic frame(input int f);
        int w;
        logic [15:0] r;
        drain();
        tv_mode = f != 0;
        flicker_en = f == 1;
        hscale_step = (f == 2) ? 10'h080 : dco_pkg::SCALE_ONE;
        image_x = (f == 2) ? 11'h002 : 11'h000;
        // vertical step 2.0 clips the window to the first ten lines
        vscale_step = (f == 2) ? 10'h200 : dco_pkg::SCALE_ONE;
        image_h = (f == 2) ? 13'h014 : 13'h1000;
        // cursor set up in retrace, off in last frame
        cursor_en = f != 2;
        cursor_x = 11'(4 + 4 * f);
        cursor_y = 11'(4 + f);
        for (int i = 0; i < 1024; i++) begin
            r = 16'($random(seed));
            curmem[i] = (i % 4 == 0) ? 16'h0000 : (i % 4 == 1) ? 16'h7FFF : {~i[0], r[14:0]};
        end
        nack = 0;
        send(0, 0, 0, 0, 1, 1);
        @(negedge sys_clk);
        in_valid = 1'b0;
        repeat (3) @(negedge sys_clk);
        w = 0;
        while (fetch_busy_q === 1'b1 && w < 10000) begin
            @(negedge sys_clk);
            w++;
        end
        cmp_val(32'(nack), cursor_en ? 32'h400 : 32'h0);
        // line length a multiple of four
        for (int y = 0; y < 40; y++) begin
            for (int x = 0; x < 40; x++) send(11'(x), 11'(y), 1, 0, 0, f > 0 || y > 2);
            send(11'h028, 11'(y), 0, 1, 0, 1);
        end
    endtask

    // framestore answers a held request after a random delay
    always @(negedge sys_clk) begin
        fb_ack <= fb_req_q === 1'b1 && nack < 1024 && ($random(seed) & 1) != 0;
        fb_rdata <= curmem[fb_addr_q[10:1]];
    end

    // each answered word sits two bytes above the previous one
    always @(posedge sys_clk) begin
        if (fb_req_q === 1'b1 && fb_ack) begin
            cmp_addr(fb_addr_q, cursor_base + 24'(2 * nack));
            nack <= nack + 1;
        end
    end

    // pop the oldest note for each delivered cell, compare it when the note is marked for checking
    always @(posedge sys_clk) begin
        if (out_valid_q === 1'b1 && out_ready === 1'b1) begin
            if (exp_q.size() == 0) fail("unexpected output cell");
            else begin
                mon_exp = exp_q.pop_front();
                mon_chk = chk_q.pop_front();
                if (mon_chk) cmp_pix(out_pix_q, mon_exp);
            end
        end
    end

    // main sequence: reset, fill until refused, three frames
    initial begin
        int n, st;
        for (int i = 0; i < 64; i++) bgtab[i] = 30'($random(seed)) & {3{10'h3FC}};
        repeat (5) @(posedge sys_clk);
        @(negedge sys_clk);
        rst = 1'b0;
        cmp_val({5'h0, fb_req_q, fetch_busy_q, out_valid_q, fb_addr_q}, 32'h0);
        cmp_pix(out_pix_q, '0);
        hold = 1'b1;
        n = 0;
        st = 0;
        while (st < 8) begin
            if (in_ready_q === 1'b1) begin
                send(11'(n), 0, 0, 0, 0, 1);
                n++;
                st = 0;
            end else begin
                @(negedge sys_clk);
                in_valid = 1'b0;
                st++;
            end
        end
        cmp_val(32'(n >= 28 && n <= 40), 32'h1);
        hold = 1'b0;
        for (int f = 0; f < 3; f++) frame(f);
        drain();
        conclude();
    end

    // watchdog against a hung handshake, a few times the expected run
    initial begin
        #250000;
        fail("watchdog expired");
        conclude();
    end
endmodule
`default_nettype wire
